// *** design/fec_page_mem.sv ***
`timescale 1ns/1ps
module fec_page_mem
    import fec_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // erase commands
    input  wire logic       wipe_page,
    input  wire logic [6:0] wipe_idx,
    input  wire logic       wipe_all,
    // read port
    input  wire logic [7:0] rd_idx,
    output logic            rd_erased
);

    // ----------------------------------------------------------------
    // erased flags, one per page plus the guarded block
    // ----------------------------------------------------------------
    logic [FEC_PAGES:0] erased;
    logic [FEC_PAGES:0] next_erased;
    logic               next_rd_erased;

    genvar g;
    generate
        for (g = 0; g < FEC_PAGES; g = g + 1) begin : g_page
            always_comb begin
                next_erased[g] = erased[g] | wipe_all | (wipe_page && (wipe_idx == FEC_PAGE_W'(g)));
            end
        end
    endgenerate

    always_comb begin
        next_erased[FEC_PAGES] = erased[FEC_PAGES] | wipe_all;
        next_rd_erased         = erased[rd_idx];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erased    <= '0;
            rd_erased <= 1'b0;
        end else begin
            erased    <= next_erased;
            rd_erased <= next_rd_erased;
        end
    end

endmodule

// *** design/fec_top.sv ***
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module fec_top
    import fec_pkg::*;
#(
    parameter int PAGE_CYC  = FEC_PAGE_CYC,
    parameter int WHOLE_CYC = FEC_WHOLE_CYC
) (
    // apb slave
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [FEC_ADDR_W-1:0] paddr,
    input  wire logic [FEC_DATA_W-1:0] pwdata,
    output logic      [FEC_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // array high voltage
    output logic                       pump_on,
    output logic                       array_ready
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fec_ctrl_type            ctrl;
    fec_ctrl_type            next_ctrl;
    fec_ctrl_type            wr_ctrl;
    fec_state_type           state;
    fec_state_type           next_state;
    logic [FEC_CNT_W-1:0]    cnt;
    logic [FEC_CNT_W-1:0]    next_cnt;
    logic [15:0]             target;
    logic [15:0]             next_target;
    logic                    done;
    logic                    next_done;
    logic                    wipe_page;
    logic                    next_wipe_page;
    logic                    wipe_all;
    logic                    next_wipe_all;
    logic [FEC_DATA_W-1:0]   next_prdata;
    logic                    next_pready;
    logic                    next_pslverr;
    logic                    next_pump_on;
    logic                    next_array_ready;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic                    access;
    logic                    commit;
    logic                    array_hit;
    logic                    ctrl_wr;
    logic                    array_wr;
    logic                    busy;
    logic                    sel;
    logic [15:0]             flash_addr;
    logic [7:0]              rd_idx;
    logic                    rd_erased;
    logic [FEC_CNT_W-1:0]    hold_need;

    always_comb begin
        access     = psel & penable;
        commit     = access & pready;
        array_hit  = paddr[FEC_ARRAY_SEL_B];
        flash_addr = paddr[17:2];
        ctrl_wr    = commit & pwrite & (paddr == FEC_OFS_CONTROL);
        array_wr   = commit & pwrite & array_hit & (paddr[1:0] == 2'b00);
        busy       = ctrl.pump_enable | (state == FEC_RECOVER);
        sel        = ctrl.wipe_select | ctrl.write_select;
        wr_ctrl    = fec_ctrl_type'(pwdata[7:0]);
        if (flash_addr >= FEC_GUARD_FIRST) begin
            rd_idx = FEC_GUARD_IDX;
        end else begin
            rd_idx = {1'b0, flash_addr[15:FEC_PAGE_LSB]};
        end
        if (ctrl.whole_array_select) begin
            hold_need = FEC_CNT_W'(WHOLE_CYC);
        end else begin
            hold_need = FEC_CNT_W'(PAGE_CYC);
        end
    end

    fec_page_mem u_mem (
        .pclk      (pclk),
        .presetn   (presetn),
        .wipe_page (wipe_page),
        .wipe_idx  (target[15:FEC_PAGE_LSB]),
        .wipe_all  (wipe_all),
        .rd_idx    (rd_idx),
        .rd_erased (rd_erased)
    );

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_wr) begin
            if (!(wr_ctrl.wipe_select & wr_ctrl.write_select)) begin
                next_ctrl.wipe_select  = wr_ctrl.wipe_select;
                next_ctrl.write_select = wr_ctrl.write_select;
            end
            next_ctrl.whole_array_select = wr_ctrl.whole_array_select;
            if (!wr_ctrl.pump_enable) begin
                next_ctrl.pump_enable = 1'b0;
            end else if ((state == FEC_ARMED) && (next_ctrl.wipe_select | next_ctrl.write_select)) begin
                next_ctrl.pump_enable = 1'b1;
            end
        end
        next_ctrl.reserved = '0;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_target    = target;
        next_done      = done;
        next_wipe_page = 1'b0;
        next_wipe_all  = 1'b0;
        unique case (state)
            FEC_IDLE: begin
                if (sel) begin
                    next_state = FEC_SELECTED;
                end
            end
            FEC_SELECTED: begin
                if (!sel) begin
                    next_state = FEC_IDLE;
                end else if (array_wr) begin
                    next_target = flash_addr;
                    next_cnt    = '0;
                    next_state  = FEC_SETUP;
                end
            end
            FEC_SETUP: begin
                next_cnt = cnt + 1'b1;
                if (!sel) begin
                    next_state = FEC_IDLE;
                end else if (cnt == FEC_CNT_W'(FEC_SETUP_CYC - 1)) begin
                    next_state = FEC_ARMED;
                end
            end
            FEC_ARMED: begin
                if (!sel) begin
                    next_state = FEC_IDLE;
                end else if (ctrl.pump_enable) begin
                    next_cnt   = '0;
                    next_done  = 1'b0;
                    next_state = FEC_HIGHV;
                end
            end
            FEC_HIGHV: begin
                if (cnt != '1) begin
                    next_cnt = cnt + 1'b1;
                end
                // decide on the clearing write itself, while the old selects still stand
                if (!next_ctrl.pump_enable) begin
                    next_cnt   = '0;
                    next_state = FEC_RECOVER;
                end else if (!(next_ctrl.wipe_select | next_ctrl.write_select)) begin
                    next_state = FEC_HOLD;
                    if (ctrl.wipe_select && (cnt >= hold_need)) begin
                        next_done      = 1'b1;
                        next_wipe_all  = ctrl.whole_array_select;
                        next_wipe_page = !ctrl.whole_array_select;
                    end
                end
            end
            FEC_HOLD: begin
                if (!next_ctrl.pump_enable) begin
                    next_cnt   = '0;
                    next_state = FEC_RECOVER;
                end
            end
            FEC_RECOVER: begin
                next_cnt = cnt + 1'b1;
                if (cnt == FEC_CNT_W'(FEC_RECOVER_CYC - 1)) begin
                    next_state = FEC_IDLE;
                end
            end
            default: begin
                next_state = FEC_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // apb answer and outputs
    // ----------------------------------------------------------------
    always_comb begin
        next_pready      = access & ~pready;
        next_prdata      = prdata;
        next_pslverr     = pslverr;
        next_pump_on     = next_ctrl.pump_enable;
        next_array_ready = ~(next_ctrl.pump_enable | (next_state == FEC_RECOVER));
        if (access & ~pready) begin
            next_prdata  = '0;
            next_pslverr = 1'b0;
            if (array_hit) begin
                if (busy || (paddr[1:0] != 2'b00)) begin
                    next_pslverr = 1'b1;
                end else if (!pwrite) begin
                    next_prdata[7:0] = rd_erased ? FEC_BYTE_ERASED : FEC_BYTE_WRITTEN;
                end
            end else if (paddr == FEC_OFS_CONTROL) begin
                next_prdata[7:0] = ctrl;
            end else if (paddr == FEC_OFS_TARGET) begin
                next_prdata[15:0] = target;
            end else if (paddr == FEC_OFS_STATUS) begin
                next_prdata[6:0]            = state;
                next_prdata[FEC_ST_DONE_B]  = done;
                next_prdata[FEC_ST_READY_B] = array_ready;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl        <= FEC_CTRL_RESET;
            state       <= FEC_IDLE;
            cnt         <= '0;
            target      <= '0;
            done        <= 1'b0;
            wipe_page   <= 1'b0;
            wipe_all    <= 1'b0;
            prdata      <= '0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            pump_on     <= 1'b0;
            array_ready <= 1'b1;
        end else begin
            ctrl        <= next_ctrl;
            state       <= next_state;
            cnt         <= next_cnt;
            target      <= next_target;
            done        <= next_done;
            wipe_page   <= next_wipe_page;
            wipe_all    <= next_wipe_all;
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
            pump_on     <= next_pump_on;
            array_ready <= next_array_ready;
        end
    end

endmodule

// *** pkg/fec_pkg.sv ***
package fec_pkg;

    // ----------------------------------------------------------------
    // bus and address map
    // ----------------------------------------------------------------
    localparam int          FEC_ADDR_W       = 19;
    localparam int          FEC_DATA_W       = 32;
    localparam logic [18:0] FEC_OFS_CONTROL  = 19'h00000;
    localparam logic [18:0] FEC_OFS_TARGET   = 19'h00004;
    localparam logic [18:0] FEC_OFS_STATUS   = 19'h00008;
    localparam int          FEC_ARRAY_SEL_B  = 18;
    localparam logic [15:0] FEC_GUARD_FIRST  = 16'hffcf;
    localparam int          FEC_PAGE_LSB     = 9;
    localparam int          FEC_PAGE_W       = 7;
    localparam int          FEC_PAGES        = 128;
    localparam logic [7:0]  FEC_GUARD_IDX    = 8'h80;
    localparam logic [7:0]  FEC_BYTE_ERASED  = 8'hff;
    localparam logic [7:0]  FEC_BYTE_WRITTEN = 8'h00;

    // ----------------------------------------------------------------
    // status field positions
    // ----------------------------------------------------------------
    localparam int          FEC_ST_DONE_B    = 8;
    localparam int          FEC_ST_READY_B   = 9;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          FEC_CLK_NS       = 100;
    localparam int          FEC_T_SETUP_NS   = 5000;
    localparam int          FEC_T_RECOVER_NS = 1000;
    localparam int          FEC_T_PAGE_MS    = 20;
    localparam int          FEC_T_WHOLE_MS   = 200;
    localparam int          FEC_NS_PER_MS    = 1000000;
    localparam int          FEC_CNT_W        = 21;
    localparam int          FEC_SETUP_CYC    = (FEC_T_SETUP_NS + FEC_CLK_NS - 1) / FEC_CLK_NS;
    localparam int          FEC_RECOVER_CYC  = (FEC_T_RECOVER_NS + FEC_CLK_NS - 1) / FEC_CLK_NS;
    localparam int          FEC_PAGE_CYC     = FEC_T_PAGE_MS * (FEC_NS_PER_MS / FEC_CLK_NS);
    localparam int          FEC_WHOLE_CYC    = FEC_T_WHOLE_MS * (FEC_NS_PER_MS / FEC_CLK_NS);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] reserved;
        logic       pump_enable;
        logic       whole_array_select;
        logic       wipe_select;
        logic       write_select;
    } fec_ctrl_type;

    localparam fec_ctrl_type FEC_CTRL_RESET = '0;

    typedef enum logic [6:0] {
        FEC_IDLE     = 7'h01,
        FEC_SELECTED = 7'h02,
        FEC_SETUP    = 7'h04,
        FEC_ARMED    = 7'h08,
        FEC_HIGHV    = 7'h10,
        FEC_HOLD     = 7'h20,
        FEC_RECOVER  = 7'h40
    } fec_state_type;

endpackage

// *** verif/fec_top_props.sv ***
`timescale 1ns/1ps
module fec_top_props
    import fec_pkg::*;
#(
    parameter int PAGE_CYC  = 20,
    parameter int WHOLE_CYC = 40
) (
    // apb slave
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [FEC_ADDR_W-1:0] paddr,
    input wire logic [FEC_DATA_W-1:0] pwdata,
    input wire logic [FEC_DATA_W-1:0] prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // array high voltage
    input wire logic                  pump_on,
    input wire logic                  array_ready
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic acc_done;
    logic wr_ctrl;
    assign acc_done = psel && penable && pready;
    assign wr_ctrl  = acc_done && pwrite && paddr == FEC_OFS_CONTROL;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_pump_cause;
        $rose(pump_on) |-> $past(wr_ctrl && pwdata[3], 1) || $past(wr_ctrl && pwdata[3], 2);
    endproperty
    a_pump_cause: assert property (p_pump_cause) else $error("pump rose without a pump write");
    property p_pump_drop;
        $fell(pump_on) |-> $past(wr_ctrl && !pwdata[3], 1) || $past(wr_ctrl && !pwdata[3], 2);
    endproperty
    a_pump_drop: assert property (p_pump_drop) else $error("pump fell without a clearing write");
    property p_pump_busy;
        pump_on |-> !array_ready;
    endproperty
    a_pump_busy: assert property (p_pump_busy) else $error("array ready while pump on");
    property p_recover;
        $fell(pump_on) |-> !array_ready [*8] ##[1:12] array_ready;
    endproperty
    a_recover: assert property (p_recover) else $error("recovery time wrong");
    property p_busy_err;
        acc_done && paddr[FEC_ARRAY_SEL_B] && !array_ready |-> pslverr;
    endproperty
    a_busy_err: assert property (p_busy_err) else $error("array access while busy not refused");
    property p_interlock;
        acc_done && !pwrite && paddr == FEC_OFS_CONTROL |-> !(prdata[0] && prdata[1]);
    endproperty
    a_interlock: assert property (p_interlock) else $error("both select bits set");
    property p_byte_value;
        acc_done && !pwrite && paddr[FEC_ARRAY_SEL_B] && !pslverr |-> prdata inside {32'h0, 32'h0000_00ff};
    endproperty
    a_byte_value: assert property (p_byte_value) else $error("array byte neither erased nor written");
    property p_wait;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_wait: assert property (p_wait) else $error("ready timing wrong");
    property p_reset;
        $rose(presetn) |-> !pump_on && array_ready && !pready;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not at reset values");
    c_pump: cover property ($rose(pump_on));
    c_err: cover property (acc_done && pslverr);
    c_done: cover property (acc_done && !pwrite && paddr == FEC_OFS_STATUS && prdata[FEC_ST_DONE_B]);
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import fec_pkg::*;
;
    localparam int PAGE_CYC  = 20;
    localparam int WHOLE_CYC = 40;
    localparam int LIMIT     = 20000;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, pump_on, array_ready, err;
    logic [FEC_ADDR_W-1:0] paddr;
    logic [FEC_DATA_W-1:0] pwdata, prdata, rdata;
    int                    num_errors, cmp_count, cycles;

    fec_top #(.PAGE_CYC(PAGE_CYC), .WHOLE_CYC(WHOLE_CYC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pump_on(pump_on), .array_ready(array_ready));

    // ----------------------------------------------------------------
    // clock, timeout, tasks
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [18:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rd(input logic [18:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask
    function automatic logic [18:0] arr(input logic [15:0] a);
        return {1'b1, a, 2'b00};
    endfunction
    task automatic erase(input logic [7:0] sel, input logic [15:0] a, input int hold);
        xfer(1'b1, FEC_OFS_CONTROL, {24'h0, sel});
        xfer(1'b1, arr(a), 32'h5a);
        repeat (60) @(posedge pclk);
        xfer(1'b1, FEC_OFS_CONTROL, {24'h0, sel | 8'h08});
        repeat (3) @(posedge pclk);
        chk({31'h0, pump_on}, 32'h1);
        xfer(1'b0, arr(a), 32'h0);
        chk({31'h0, err}, 32'h1);
        rd(FEC_OFS_STATUS, 32'h010);
        repeat (hold) @(posedge pclk);
        xfer(1'b1, FEC_OFS_CONTROL, 32'h08);
        repeat (sel[2] ? 1000 : 60) @(posedge pclk);
        xfer(1'b1, FEC_OFS_CONTROL, 32'h00);
        repeat (15) @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        num_errors = 0; cmp_count = 0; cycles = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(FEC_OFS_CONTROL, 32'h0);
        rd(FEC_OFS_STATUS, 32'h201);
        rd(arr(16'h0400), 32'h0);
        xfer(1'b0, 19'h0000c, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(1'b1, FEC_OFS_CONTROL, 32'h3);
        rd(FEC_OFS_CONTROL, 32'h0);
        xfer(1'b1, FEC_OFS_CONTROL, 32'h8);
        rd(FEC_OFS_CONTROL, 32'h0);
        xfer(1'b1, FEC_OFS_CONTROL, 32'h2);
        xfer(1'b1, arr(16'h0405), 32'hff);
        rd(FEC_OFS_TARGET, 32'h0405);
        xfer(1'b1, FEC_OFS_CONTROL, 32'ha);
        rd(FEC_OFS_CONTROL, 32'h2);
        xfer(1'b1, FEC_OFS_CONTROL, 32'h0);
        repeat (15) @(posedge pclk);
        erase(8'h01, 16'h0800, 30);
        rd(FEC_OFS_STATUS, 32'h201);
        erase(8'h02, 16'h0800, 1);
        rd(FEC_OFS_STATUS, 32'h201);
        rd(arr(16'h0800), 32'h0);
        erase(8'h02, 16'h0405, PAGE_CYC + 10);
        rd(FEC_OFS_STATUS, 32'h301);
        rd(arr(16'h0400), 32'hff);
        rd(arr(16'h05ff), 32'hff);
        rd(arr(16'h03ff), 32'h0);
        rd(arr(16'h0600), 32'h0);
        erase(8'h02, 16'hffd0, PAGE_CYC + 10);
        rd(arr(16'hfe00), 32'hff);
        rd(arr(16'hffd0), 32'h0);
        rd(arr(16'hffcf), 32'h0);
        erase(8'h06, 16'h1234, WHOLE_CYC + 10);
        rd(arr(16'hffd0), 32'hff);
        rd(arr(16'hffcf), 32'hff);
        rd(arr(16'h0000), 32'hff);
        finish_test();
    end
endmodule

bind fec_top fec_top_props #(.PAGE_CYC(PAGE_CYC), .WHOLE_CYC(WHOLE_CYC)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pump_on(pump_on), .array_ready(array_ready));
